// *** hdl/amsq_pin_front.sv ***
// Pin synchronisers and serial byte assembly of the mode sequencer.
// Assumes asynchronous pins; sys_clk much faster than the serial clock.
`timescale 1ns/1ps
module amsq_pin_front
   import amsq_pkg::*;
(
   input  wire logic   sys_clk,
   input  wire logic   rst,
   input  wire logic   cs_n_pin,
   input  wire logic   sclk_pin,
   input  wire logic   din_pin,
   input  wire logic   start_sync_pin,
   input  wire logic   reset_n_pin,
   amsq_link_if.front  lk
);
   logic [PIN_COUNT-1:0] raw_pins;
   logic [PIN_COUNT-1:0] sync1;
   logic [PIN_COUNT-1:0] sync2;
   logic [PIN_COUNT-1:0] sync3;
   logic [PIN_COUNT-1:0] level;
   logic [PIN_COUNT-1:0] level_q;
   logic [PIN_COUNT-1:0] next_level;
   logic [2:0]           bit_cnt;
   logic [7:0]           shift;
   logic                 strobe7;
   logic                 strobe8;
   wire                  cs_on = ~level[PIN_CS];
   wire                  fall_sclk = cs_on & level_q[PIN_SCLK] & ~level[PIN_SCLK];

   assign raw_pins = {reset_n_pin, start_sync_pin, din_pin, sclk_pin, cs_n_pin};

   // ****************************************
   // Three-stage sync, level moves once stages two and three agree
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++)
      begin : g_pin
         assign next_level[g] = (sync2[g] == sync3[g]) ? sync3[g] : level[g];
      end
   endgenerate

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sync1   <= PIN_IDLE;
         sync2   <= PIN_IDLE;
         sync3   <= PIN_IDLE;
         level   <= PIN_IDLE;
         level_q <= PIN_IDLE;
      end
      else
      begin
         sync1   <= raw_pins;
         sync2   <= sync1;
         sync3   <= sync2;
         level   <= next_level;
         level_q <= level;
      end
   end

   // ****************************************
   // Byte assembly, bits taken on falling serial clock
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst || !cs_on)
      begin
         bit_cnt <= 3'h0;
         strobe7 <= 1'b0;
         strobe8 <= 1'b0;
         shift   <= 8'h00;
      end
      else
      begin
         strobe7 <= fall_sclk && (bit_cnt == 3'h6);
         strobe8 <= fall_sclk && (bit_cnt == 3'h7);
         if (fall_sclk)
         begin
            shift   <= {shift[6:0], level[PIN_DIN]};
            bit_cnt <= bit_cnt + 3'h1;
         end
      end
   end

   assign lk.cs_active     = cs_on;
   assign lk.sclk_fall     = fall_sclk;
   assign lk.sclk_rise     = cs_on & ~level_q[PIN_SCLK] & level[PIN_SCLK];
   assign lk.start_rise    = level[PIN_START] & ~level_q[PIN_START];
   assign lk.start_fall    = ~level[PIN_START] & level_q[PIN_START];
   assign lk.reset_pin_low = ~level[PIN_RST];
   assign lk.strobe7       = strobe7;
   assign lk.strobe8       = strobe8;
   assign lk.rx_byte       = shift;
endmodule // amsq_pin_front

// *** hdl/amsq_sequencer.sv ***
// Operating-mode sequencer of a delta-sigma converter with its serial port.
// Assumes a host acting as mode-1 serial master; pins are asynchronous.
`timescale 1ns/1ps
module amsq_sequencer
   import amsq_pkg::*;
#(
   parameter int INIT_CYCLES = POR_CYCLES,
   parameter int CONV_CYCLES = CONV_TCLK
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        cs_n_pin,
   input  wire logic        sclk_pin,
   input  wire logic        din_pin,
   input  wire logic        start_sync_pin,
   input  wire logic        reset_n_pin,
   input  wire logic [15:0] conv_result,
   output logic             dout,
   output logic             dout_oe,
   output logic             data_ready_out_n,
   output logic             filter_reset,
   output logic             core_clk_en,
   output logic             amp_power_on,
   output logic             ref_power_on,
   output logic             excitation_on,
   output logic             ext_clock_sel
);
   localparam int            CW          = $clog2(CONV_CYCLES);
   localparam int            IW          = $clog2(INIT_CYCLES + 1);
   localparam logic [CW-1:0] CONV_LAST   = CW'(CONV_CYCLES - 1);
   localparam logic [CW-1:0] DATA_READY_OUT_RISE   = CW'(CONV_CYCLES - DATA_READY_OUT_PULSE_TCLK);
   localparam logic [IW-1:0] INIT_LAST   = IW'(INIT_CYCLES - 1);

   amsq_link_if lk ();

   amsq_pin_front u_front (
      .sys_clk        (sys_clk),
      .rst            (rst),
      .cs_n_pin       (cs_n_pin),
      .sclk_pin       (sclk_pin),
      .din_pin        (din_pin),
      .start_sync_pin (start_sync_pin),
      .reset_n_pin    (reset_n_pin),
      .lk             (lk)
   );

   amsq_mode_t    mode;
   amsq_phase_t   phase;
   logic [7:0]    regs [32];
   logic [CW-1:0] conv_cnt;
   logic [IW-1:0] init_cnt;
   logic          not_ready;
   logic          por_flag;
   logic          stop_pend;
   logic          act_start;
   logic          act_stop;
   logic          act_sleep;
   logic          act_wake;
   logic [4:0]    addr;
   logic [4:0]    left;
   logic          wr_seq;
   logic [15:0]   tx;
   logic [4:0]    tx_bits;
   logic          shifting;
   logic [15:0]   result;

   // ****************************************
   // Command decode
   // ****************************************
   wire [7:0] rx         = lk.rx_byte;
   wire       is_pd      = (mode == MD_SLEEP_COMMAND);
   wire       is_conv    = (mode == MD_CONVERT);
   wire       single_mode = regs[REG_RATE][RATE_MODE_BIT];
   wire       cmd7_hit   = lk.strobe7 && (phase == PH_CMD);
   wire       cmd8_hit   = lk.strobe8 && (phase == PH_CMD);
   wire       dec_wake   = cmd7_hit && (rx[6:0] == CMD7_WAKE);
   wire       dec_sleep  = cmd7_hit && (rx[6:0] == CMD7_SLEEP) && !is_pd;
   wire       dec_reset  = cmd7_hit && (rx[6:0] == CMD7_RESET) && !is_pd;
   wire       dec_start  = cmd7_hit && (rx[6:0] == CMD7_START) && !is_pd;
   wire       dec_stop   = cmd7_hit && (rx[6:0] == CMD7_STOP) && !is_pd;
   wire       cal_code   = (rx == CMD_SYSTEM_OFFSET_CAL_COMMAND) || (rx == CMD_SYSTEM_GAIN_CAL_COMMAND) || (rx == CMD_SELF_OFFSET_CAL_COMMAND);
   wire       dec_cal    = cmd8_hit && cal_code && is_conv;
   wire       dec_rdata  = cmd8_hit && (rx[7:1] == CMD7_RDATA);
   wire       dec_register_read_command   = cmd8_hit && (rx[7:5] == PFX_REGISTER_READ_COMMAND);
   wire       dec_register_write_command   = cmd8_hit && (rx[7:5] == PFX_REGISTER_WRITE_COMMAND);
   wire       pin_start  = lk.start_rise && !is_pd;
   wire       pin_stop   = lk.start_fall && is_conv && !single_mode;
   wire       soft_reset = rst || lk.reset_pin_low || dec_reset;
   wire       reg_we     = lk.strobe8 && (phase == PH_DATA) && wr_seq && !is_pd;
   wire       status_we  = reg_we && (addr == REG_STATUS);
   wire       conv_end   = is_conv && (conv_cnt == CONV_LAST) && !act_start && !act_sleep;
   wire       data_ready_out_fall  = conv_end;
   wire [4:0] rd_addr    = (phase == PH_ARG) ? addr : addr + 5'h01;
   wire [7:0] status_byte = {por_flag, not_ready, 6'h00};
   wire [7:0] rd_byte    = (rd_addr == REG_STATUS) ? status_byte : regs[rd_addr];
   wire       load_byte  = lk.strobe8 && !wr_seq &&
                           ((phase == PH_ARG) || ((phase == PH_DATA) && (left != 5'h00)));
   wire [1:0] amp_field  = regs[REG_GAIN][AMP_EN_LSB +: 2];
   wire [1:0] ref_field  = regs[REG_REFCTL][REF_PWR_LSB +: 2];

   // ****************************************
   // Two-clock action delay
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (soft_reset)
      begin
         act_start <= 1'b0;
         act_stop  <= 1'b0;
         act_sleep <= 1'b0;
         act_wake  <= 1'b0;
      end
      else
      begin
         act_start <= dec_start || pin_start || dec_cal;
         act_stop  <= dec_stop || pin_stop;
         act_sleep <= dec_sleep;
         act_wake  <= dec_wake;
      end
   end

   // ****************************************
   // Operating mode
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (soft_reset)
      begin
         mode      <= MD_STANDBY;
         conv_cnt  <= '0;
         stop_pend <= 1'b0;
      end
      else
      begin
         unique case (mode)
            MD_STANDBY:
            begin
               conv_cnt  <= '0;
               stop_pend <= 1'b0;
               if (act_start)
                  mode <= MD_CONVERT;
               else if (act_sleep)
                  mode <= MD_SLEEP_COMMAND;
            end
            MD_CONVERT:
            begin
               if (act_sleep)
                  mode <= MD_SLEEP_COMMAND;
               else if (act_start)
               begin
                  conv_cnt  <= '0;
                  stop_pend <= 1'b0;
               end
               else if (conv_end)
               begin
                  conv_cnt <= '0;
                  if (single_mode || stop_pend || act_stop)
                     mode <= MD_STANDBY;
               end
               else
               begin
                  conv_cnt <= conv_cnt + CW'(1);
                  if (act_stop)
                     stop_pend <= 1'b1;
               end
            end
            MD_SLEEP_COMMAND:
            begin
               conv_cnt <= '0;
               if (act_wake)
                  mode <= MD_STANDBY;
            end
         endcase
      end
   end

   // ****************************************
   // Data ready and result capture
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (soft_reset)
      begin
         data_ready_out_n <= 1'b1;
         result           <= 16'h0000;
      end
      else if (data_ready_out_fall)
      begin
         data_ready_out_n <= 1'b0;
         result           <= conv_result;
      end
      else if (lk.sclk_rise || lk.start_rise ||
               (is_conv && (conv_cnt == DATA_READY_OUT_RISE)))
         data_ready_out_n <= 1'b1;
   end

   // ****************************************
   // Power-on configuration and status
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         init_cnt  <= '0;
         not_ready <= 1'b1;
         por_flag  <= 1'b0;
      end
      else if (not_ready)
      begin
         if (init_cnt == INIT_LAST)
         begin
            not_ready <= 1'b0;
            por_flag  <= 1'b1;
         end
         else
            init_cnt <= init_cnt + IW'(1);
      end
      else if (status_we && !rx[STATUS_POR_BIT])
         por_flag <= 1'b0;
   end

   // ****************************************
   // Register file, kept through power-down
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (soft_reset)
      begin
         for (int i = 0; i < 32; i++)
            regs[i] <= amsq_default(5'(i));
      end
      else if (reg_we)
         regs[addr] <= rx;
   end

   // ****************************************
   // Serial transaction phase
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (soft_reset || !lk.cs_active)
      begin
         phase  <= PH_CMD;
         addr   <= 5'h00;
         left   <= 5'h00;
         wr_seq <= 1'b0;
      end
      else if (lk.strobe8)
      begin
         unique case (phase)
            PH_CMD:
            begin
               if (dec_register_read_command || dec_register_write_command)
                  phase <= PH_ARG;
               addr   <= rx[4:0];
               wr_seq <= dec_register_write_command;
            end
            PH_ARG:
            begin
               phase <= PH_DATA;
               left  <= rx[4:0];
            end
            PH_DATA:
            begin
               addr <= addr + 5'h01;
               left <= left - 5'h01;
               if (left == 5'h00)
                  phase <= PH_CMD;
            end
         endcase
      end
   end

   // ****************************************
   // Shared output: data bits on rising edge, else ready
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (soft_reset || !lk.cs_active)
      begin
         tx       <= 16'h0000;
         tx_bits  <= 5'h00;
         shifting <= 1'b0;
         dout     <= 1'b1;
         dout_oe  <= 1'b0;
      end
      else
      begin
         dout_oe <= 1'b1;
         if (dec_rdata)
         begin
            tx      <= result;
            tx_bits <= 5'h10;
         end
         else if (load_byte)
         begin
            tx      <= {rd_byte, 8'h00};
            tx_bits <= 5'h08;
         end
         else if (lk.sclk_rise && (tx_bits != 5'h00))
         begin
            tx      <= {tx[14:0], 1'b0};
            tx_bits <= tx_bits - 5'h01;
         end
         if (lk.sclk_rise && (tx_bits != 5'h00))
         begin
            dout     <= tx[15];
            shifting <= 1'b1;
         end
         else if (lk.sclk_fall && (tx_bits == 5'h00))
            shifting <= 1'b0;
         else if (!shifting)
            dout <= data_ready_out_n;
      end
   end

   // ****************************************
   // Power and clock controls
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         filter_reset  <= 1'b1;
         core_clk_en   <= 1'b0;
         amp_power_on  <= 1'b0;
         ref_power_on  <= 1'b0;
         excitation_on <= 1'b0;
         ext_clock_sel <= 1'b0;
      end
      else
      begin
         filter_reset  <= !is_conv;
         core_clk_en   <= is_conv;
         amp_power_on  <= !is_pd && (amp_field != FIELD_OFF);
         ref_power_on  <= (ref_field != FIELD_OFF) && (!is_pd || ref_field == REF_KEEP_ON);
         excitation_on <= !is_pd && (ref_field != FIELD_OFF);
         ext_clock_sel <= regs[REG_CLKSEL][CLK_EXT_BIT];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || lk.reset_pin_low);

   por_flag_set_a: assert property ($fell(not_ready) |-> por_flag && !$past(por_flag))
      else $error("power-on flag not set at end of init");
   init_done_a: assert property ($fell(not_ready) |-> init_cnt == INIT_LAST)
      else $error("init-done cleared at wrong time");
   sleep_entry_a: assert property (dec_sleep |-> !is_pd ##1 !is_pd ##1 is_pd)
      else $error("power-down not entered two clocks after command");
   wake_only_a: assert property (is_pd && !act_wake |=> is_pd)
      else $error("power-down left without wake");
   pd_no_write_a: assert property (is_pd |=> $stable(regs[REG_GAIN]))
      else $error("register changed in power-down");
   idle_gated_a: assert property (mode == MD_STANDBY [*2] |-> filter_reset && !core_clk_en)
      else $error("filter or core clock active in standby");
   cal_standby_a: assert property (!is_conv && cmd8_hit && cal_code && !pin_start
                                   |=> !act_start)
      else $error("calibration decoded outside conversion");
   start_delay_a: assert property (dec_start || pin_start |-> ##2 is_conv && conv_cnt == '0)
      else $error("conversion did not start two clocks after start");
   single_done_a: assert property (conv_end && single_mode |=>
                                   mode == MD_STANDBY && !data_ready_out_n)
      else $error("single-shot did not return to standby");
   data_ready_out_release_a: assert property (!data_ready_out_n && lk.sclk_rise && !data_ready_out_fall
                                    |=> data_ready_out_n)
      else $error("data ready not released on serial rise");
   cs_float_a: assert property (!lk.cs_active |=> !dout_oe)
      else $error("shared output driven with chip select high");
endmodule // amsq_sequencer

// *** include/amsq_link_if.sv ***
// Filtered pin events and received serial bytes, front end to core.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface amsq_link_if;
   logic       cs_active;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       start_rise;
   logic       start_fall;
   logic       reset_pin_low;
   logic       strobe7;
   logic       strobe8;
   logic [7:0] rx_byte;
   modport front (output cs_active, sclk_rise, sclk_fall, start_rise, start_fall,
                  reset_pin_low, strobe7, strobe8, rx_byte);
   modport core  (input  cs_active, sclk_rise, sclk_fall, start_rise, start_fall,
                  reset_pin_low, strobe7, strobe8, rx_byte);
endinterface

// *** include/amsq_pkg.sv ***
// Constants and types of the converter mode sequencer.
// Assumes a 40 MHz core clock equal to the converter clock period.
package amsq_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int  CLK_HZ          = 40_000_000;
   localparam real POR_TIME_MS     = 2.2;
   localparam int  POR_CYCLES      = int'($ceil(POR_TIME_MS * CLK_HZ / 1000.0));
   localparam int  CMD_DELAY_TCLK  = 2;
   localparam int  DATA_READY_OUT_PULSE_TCLK = 24;
   localparam int  CONV_TCLK       = 1024;
   // ****************************************
   // Register map and fields
   // ****************************************
   localparam logic [4:0] REG_STATUS  = 5'h01;
   localparam logic [4:0] REG_GAIN    = 5'h03;
   localparam logic [4:0] REG_RATE    = 5'h04;
   localparam logic [4:0] REG_REFCTL  = 5'h05;
   localparam logic [4:0] REG_CLKSEL  = 5'h06;
   localparam int         STATUS_POR_BIT  = 7;
   localparam int         STATUS_NRDY_BIT = 6;
   localparam int         AMP_EN_LSB      = 6;
   localparam int         RATE_MODE_BIT   = 5;
   localparam int         REF_PWR_LSB     = 0;
   localparam int         CLK_EXT_BIT     = 0;
   localparam logic [1:0] FIELD_OFF       = 2'h0;
   localparam logic [1:0] REF_KEEP_ON     = 2'h2;
   localparam logic [7:0] GAIN_RST   = 8'h00;
   localparam logic [7:0] RATE_RST   = 8'h00;
   localparam logic [7:0] REFCTL_RST = 8'h00;
   localparam logic [7:0] OTHER_RST  = 8'h00;
   // ****************************************
   // Command codes (upper seven bits where the last bit is free)
   // ****************************************
   localparam logic [6:0] CMD7_WAKE  = 7'h01;
   localparam logic [6:0] CMD7_SLEEP = 7'h02;
   localparam logic [6:0] CMD7_RESET = 7'h03;
   localparam logic [6:0] CMD7_START = 7'h04;
   localparam logic [6:0] CMD7_STOP  = 7'h05;
   localparam logic [6:0] CMD7_RDATA = 7'h09;
   localparam logic [7:0] CMD_SYSTEM_OFFSET_CAL_COMMAND = 8'h16;
   localparam logic [7:0] CMD_SYSTEM_GAIN_CAL_COMMAND = 8'h17;
   localparam logic [7:0] CMD_SELF_OFFSET_CAL_COMMAND = 8'h19;
   localparam logic [2:0] PFX_REGISTER_READ_COMMAND   = 3'h1;
   localparam logic [2:0] PFX_REGISTER_WRITE_COMMAND   = 3'h2;
   // ****************************************
   // Pins and types
   // ****************************************
   localparam int         PIN_COUNT = 5;
   localparam int         PIN_CS    = 0;
   localparam int         PIN_SCLK  = 1;
   localparam int         PIN_DIN   = 2;
   localparam int         PIN_START = 3;
   localparam int         PIN_RST   = 4;
   localparam logic [4:0] PIN_IDLE  = 5'h11;
   typedef enum logic [2:0] {
      MD_STANDBY = 3'b001, MD_CONVERT = 3'b010, MD_SLEEP_COMMAND = 3'b100
   } amsq_mode_t;
   typedef enum logic [2:0] {
      PH_CMD = 3'b001, PH_ARG = 3'b010, PH_DATA = 3'b100
   } amsq_phase_t;
   function automatic logic [7:0] amsq_default(input logic [4:0] a);
      amsq_default = (a == REG_GAIN) ? GAIN_RST : (a == REG_RATE) ? RATE_RST :
                     (a == REG_REFCTL) ? REFCTL_RST : OTHER_RST;
   endfunction
endpackage

// *** testbench/amsq_host_model.sv ***
// Mode-1 serial host model driving the sequencer's serial pins.
// Assumes sys_clk from the bench and a pull-up on the shared output line.
`timescale 1ns/1ps
module amsq_host_model
(
   input  wire logic sys_clk,
   input  wire logic dout,
   input  wire logic dout_oe,
   output logic      cs_n_pin,
   output logic      sclk_pin,
   output logic      din_pin
);
   // Released line reads as the pull-up level
   wire miso = dout_oe ? dout : 1'b1;
   // Half period of 4 cycles gives the 200 ns serial clock
   task automatic half();
      repeat (4) @(posedge sys_clk);
      #2;
   endtask
   task automatic sel(input logic val);
      cs_n_pin = val;
      half();
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx_out);
      for (int i = 7; i >= 0; i--)
      begin
         sclk_pin = 1'b1;
         din_pin  = tx[i];
         half();
         sclk_pin  = 1'b0;
         // Sample in the middle of the low half: the pin synchronisers delay dout by 5 cycles
         repeat (2) @(posedge sys_clk);
         #2;
         rx_out[i] = miso;
         repeat (2) @(posedge sys_clk);
         #2;
      end
   endtask
   initial
   begin
      cs_n_pin = 1'b1;
      sclk_pin = 1'b0;
      din_pin  = 1'b0;
   end
endmodule // amsq_host_model

// *** testbench/amsq_sequencer_tb_top.sv ***
// Self-checking bench of the mode sequencer against a register model.
// Assumes the host model module and the shared package are compiled first.
`timescale 1ns/1ps
module amsq_sequencer_tb_top import amsq_pkg::*;;
   logic        sys_clk = 1'b0;
   logic        rst, start_sync_pin, reset_n_pin;
   logic [15:0] conv_result;
   logic        cs_n_pin, sclk_pin, din_pin, dout, dout_oe, data_ready_out_n;
   logic        filter_reset, core_clk_en, amp_power_on, ref_power_on, excitation_on;
   logic        ext_clock_sel;
   logic [7:0]  regs [32];
   logic [7:0]  rx, v;
   int          fail_count = 0, n_compared = 0, seed = 37;
   bit          asleep = 1'b0;
   always #12.5 sys_clk = ~sys_clk;
   amsq_sequencer #(.INIT_CYCLES(20), .CONV_CYCLES(256)) u_amsq_sequencer (
      .sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
      .din_pin(din_pin), .start_sync_pin(start_sync_pin), .reset_n_pin(reset_n_pin),
      .conv_result(conv_result), .dout(dout), .dout_oe(dout_oe),
      .data_ready_out_n(data_ready_out_n), .filter_reset(filter_reset),
      .core_clk_en(core_clk_en), .amp_power_on(amp_power_on), .ref_power_on(ref_power_on),
      .excitation_on(excitation_on), .ext_clock_sel(ext_clock_sel));
   amsq_host_model u_amsq_host_model (.sys_clk(sys_clk), .dout(dout), .dout_oe(dout_oe),
      .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .din_pin(din_pin));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic send(input logic [7:0] b);
      u_amsq_host_model.sel(1'b0);
      u_amsq_host_model.xfer(b, rx);
      u_amsq_host_model.sel(1'b1);
   endtask
   task automatic reg_op(input logic wr, input logic [4:0] a, input logic [7:0] d);
      u_amsq_host_model.sel(1'b0);
      u_amsq_host_model.xfer({wr ? PFX_REGISTER_WRITE_COMMAND : PFX_REGISTER_READ_COMMAND, a}, rx);
      u_amsq_host_model.xfer(8'h00, rx);
      u_amsq_host_model.xfer(d, rx);
      u_amsq_host_model.sel(1'b1);
      if (wr && !asleep) regs[a] = d;
      if (!wr) chk("register", {8'h00, rx}, {8'h00, regs[a]});
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 300 && data_ready_out_n !== 1'b0; i++) cyc(1);
      chk("ready low", {15'h0, data_ready_out_n}, 16'h0000);
   endtask
   task automatic read_data(input logic [15:0] exp);
      logic [7:0] hi;
      u_amsq_host_model.sel(1'b0);
      u_amsq_host_model.xfer({CMD7_RDATA, 1'b0}, rx);
      u_amsq_host_model.xfer(8'h00, hi);
      u_amsq_host_model.xfer(8'h00, rx);
      u_amsq_host_model.sel(1'b1);
      chk("result", {hi, rx}, exp);
   endtask
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      cyc(40000);
      fail_count++;
      print_verdict();
   end
   initial
   begin
      rst = 1'b1;
      start_sync_pin = 1'b0;
      reset_n_pin = 1'b1;
      conv_result = 16'h0000;
      foreach (regs[a]) regs[a] = 8'h00;
      cyc(6);
      rst = 1'b0;
      chk("idle", {filter_reset, core_clk_en, data_ready_out_n, dout_oe, ext_clock_sel},
          16'h0014);
      cyc(40);
      regs[REG_STATUS][STATUS_POR_BIT] = 1'b1;
      reg_op(1'b0, REG_STATUS, 8'h00);
      for (int k = 0; k < 3; k++)
      begin
         v = 8'($random(seed));
         reg_op(1'b1, REG_GAIN, v);
         reg_op(1'b1, REG_REFCTL, v);
         chk("power", {amp_power_on, ref_power_on, excitation_on},
             {v[7:6] != FIELD_OFF, v[1:0] != FIELD_OFF, v[1:0] != FIELD_OFF});
      end
      $display("TEST power fields done");
      reg_op(1'b1, REG_RATE, 8'h00);
      conv_result = 16'($random(seed));
      send({CMD7_START, 1'b0});
      chk("run", {filter_reset, core_clk_en}, 16'h0001);
      wait_ready();
      send({CMD7_STOP, 1'b1});
      chk("stop", {data_ready_out_n, core_clk_en}, 16'h0003);
      send({CMD7_START, 1'b0});
      wait_ready();
      chk("resync", {15'h0, core_clk_en}, 16'h0001);
      send({CMD7_STOP, 1'b1});
      wait_ready();
      cyc(3);
      chk("standby", {filter_reset, core_clk_en}, 16'h0002);
      read_data(conv_result);
      $display("TEST continuous done");
      reg_op(1'b1, REG_RATE, 8'h20);
      conv_result = 16'($random(seed));
      start_sync_pin = 1'b1;
      cyc(8);
      chk("pin start", {data_ready_out_n, core_clk_en}, 16'h0003);
      wait_ready();
      cyc(3);
      chk("one shot", {filter_reset, core_clk_en}, 16'h0002);
      read_data(conv_result);
      start_sync_pin = 1'b0;
      send(CMD_SYSTEM_OFFSET_CAL_COMMAND);
      chk("no cal", {filter_reset, core_clk_en}, 16'h0002);
      $display("TEST single shot done");
      reg_op(1'b1, REG_GAIN, 8'hC0);
      send({CMD7_SLEEP, 1'b1});
      asleep = 1'b1;
      chk("asleep", {amp_power_on, core_clk_en}, 16'h0000);
      reg_op(1'b1, REG_GAIN, 8'h55);
      send({CMD7_RESET, 1'b0});
      reg_op(1'b0, REG_GAIN, 8'h00);
      send({CMD7_WAKE, 1'b1});
      asleep = 1'b0;
      chk("awake", {amp_power_on, filter_reset}, 16'h0003);
      $display("TEST power down done");
      send({CMD7_RESET, 1'b0});
      regs[REG_GAIN] = GAIN_RST;
      regs[REG_REFCTL] = REFCTL_RST;
      regs[REG_RATE] = RATE_RST;
      reg_op(1'b0, REG_GAIN, 8'h00);
      reg_op(1'b1, REG_GAIN, 8'hC0);
      reset_n_pin = 1'b0;
      cyc(6);
      reset_n_pin = 1'b1;
      cyc(10);
      regs[REG_GAIN] = GAIN_RST;
      reg_op(1'b0, REG_GAIN, 8'h00);
      $display("TEST resets done");
      print_verdict();
   end
endmodule // amsq_sequencer_tb_top
